//--- swcp_host.sv
// swcp_host: host model driving select, serial clock and data.
// assumes sdo_line is the pulled-up serial output level.
module swcp_host (
   output logic sclk,
   output logic select_n,
   output logic serial_in,
   input wire logic sdo_line
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk = 1'b0;
      select_n = 1'b1;
      serial_in = 1'b1;
   end
   // clock idles low between frames; output sampled late for the port's synchroniser delay
   task automatic frame(input logic [15:0] bits, input int n, output logic [15:0] seen);
      seen = '0;
      select_n = 1'b0;
      #8;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in = bits[i];
         #4 sclk = 1'b1;
         #16 sclk = 1'b0;
         #11 seen[i] = sdo_line;
         #1;
      end
      select_n = 1'b1;
      serial_in = ~serial_in;
   endtask : frame
endmodule : swcp_host

//--- swcp_pkg.sv
// swcp_pkg: shared constants and types of the serial wiper code port.
// assumes a 7-bit wiper code and a 128-tap resistor ladder behind it.
package swcp_pkg;

   localparam int WIPER_W = 7;
   localparam int TAP_COUNT = 128;

   // midscale value forced by reset and by the reset rising edge
   localparam logic [6:0] WIPER_MIDSCALE = 7'h40;
   // value after sys_rst; the pin-level device itself powers up undefined
   localparam logic [6:0] WIPER_RESET = 7'h40;
   // code that puts the wiper on terminal b
   localparam logic [6:0] WIPER_ZERO = 7'h00;

   // synchroniser depth and idle levels of the pins it watches
   localparam int SYNC_STAGES = 3;
   localparam int SYNC_LANES = 4;
   localparam logic [3:0] SYNC_IDLE = 4'hf;

   // lane positions inside the synchroniser vector
   localparam int LANE_SELECT_N = 0;
   localparam int LANE_RESET_N = 1;
   localparam int LANE_POWER_DOWN_N = 2;
   localparam int LANE_SERIAL_BIT = 3;

   // open-drain pad only ever pulls low
   localparam logic OD_DRIVE_LEVEL = 1'b0;

   typedef enum logic [1:0] {
      SWCP_ACTIVE = 2'b00,
      SWCP_HELD_RESET = 2'b01,
      SWCP_POWERED_DOWN = 2'b10
   } swcp_mode_t;

endpackage : swcp_pkg

//--- swcp_port.sv
// swcp_port: serial load port and wiper latch of a 128-position wiper.
// assumes a host drives select, serial clock and data; serial_out has a pull-up.
//
// Summary of operation
// - frames are seven bits, most significant bit first, assembled in that order.
// - each rising serial clock with select low and reset high shifts in one bit.
// - serial output carries the bit that entered seven shifts earlier.
// - select low enables shifting and the output driver, whatever the clock level.
// - select rising copies the shifter into the wiper latch.
// - with more than seven bits, only the last seven are kept.
// - reset low, not powered down, forces midscale and clears the output latch.
// - reset rising with select high, not powered down, loads 0x40.
// - power down opens terminal a, puts the wiper on b, releases output.
// - leaving power down restores the latched wiper setting.
// - codes still load while powered down and apply on release.
// - the wiper has no defined start; reset or programming gives a preset.
// - serial output is a pull-down-only open-drain driver.
// - the code picks one of 128 taps, zero on terminal b.
module swcp_port #(
   parameter int WIPER_W = swcp_pkg::WIPER_W,
   parameter int TAP_COUNT = swcp_pkg::TAP_COUNT
) (
   input wire logic mclk,
   input wire logic mclk_en,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic select_n,
   input wire logic serial_in,
   input wire logic midscale_reset_n,
   input wire logic power_down_n,
   output logic serial_out,
   output logic serial_out_oe_n,
   output logic [WIPER_W-1:0] wiper_latch,
   output logic [WIPER_W-1:0] wiper_tap,
   output logic [TAP_COUNT-1:0] tap_select,
   output logic terminal_a_switch,
   output logic wiper_on_b,
   output logic powered_down
);

   // serial clock domain

   logic shift_en;
   logic clear_out;
   logic [WIPER_W-1:0] shift_word;
   logic shift_out_bit;

   // select and reset are qualifiers that the host holds steady around
   // each edge, so they are read straight on the serial clock side
   assign shift_en = ~select_n & midscale_reset_n;
   assign clear_out = ~midscale_reset_n & power_down_n;

   swcp_shifter #(
      .WIDTH(WIPER_W)
   ) u_shifter (
      .sclk(sclk),
      .clk_en(mclk_en),
      .shift_en(shift_en),
      .clear_out(clear_out),
      .serial_in(serial_in),
      .word(shift_word),
      .out_bit(shift_out_bit)
   );

   // crossing into mclk

   logic [swcp_pkg::SYNC_LANES-1:0] pins_raw;
   logic [swcp_pkg::SYNC_LANES-1:0] pins_sync;

   always_comb begin
      pins_raw = '0;
      pins_raw[swcp_pkg::LANE_SELECT_N] = select_n;
      pins_raw[swcp_pkg::LANE_RESET_N] = midscale_reset_n;
      pins_raw[swcp_pkg::LANE_POWER_DOWN_N] = power_down_n;
      pins_raw[swcp_pkg::LANE_SERIAL_BIT] = shift_out_bit;
   end

   swcp_sync #(
      .WIDTH(swcp_pkg::SYNC_LANES),
      .IDLE(swcp_pkg::SYNC_IDLE)
   ) u_sync (
      .mclk(mclk),
      .mclk_en(mclk_en),
      .sys_rst(sys_rst),
      .raw(pins_raw),
      .agreed(pins_sync)
   );

   logic sel_n_s;
   logic rst_n_s;
   logic pd_n_s;
   logic out_bit_s;

   assign sel_n_s = pins_sync[swcp_pkg::LANE_SELECT_N];
   assign rst_n_s = pins_sync[swcp_pkg::LANE_RESET_N];
   assign pd_n_s = pins_sync[swcp_pkg::LANE_POWER_DOWN_N];
   assign out_bit_s = pins_sync[swcp_pkg::LANE_SERIAL_BIT];

   // mclk domain state

   typedef struct packed {
      logic [WIPER_W-1:0] latch;
      logic [WIPER_W-1:0] tap;
      logic sel_n_prev;
      logic rst_n_prev;
      logic out_cleared;
      logic out_oe_n;
      logic sw_a_closed;
      logic on_b;
      logic [TAP_COUNT-1:0] tap_sel;
      swcp_pkg::swcp_mode_t mode;
   } swcp_state_t;

   swcp_state_t st_q;
   swcp_state_t st_d;

   logic sel_rise;
   logic rst_rise;

   assign sel_rise = sel_n_s & ~st_q.sel_n_prev;
   assign rst_rise = rst_n_s & ~st_q.rst_n_prev;

   always_comb begin
      st_d = st_q;
      st_d.sel_n_prev = sel_n_s;
      st_d.rst_n_prev = rst_n_s;

      // mode from the agreed pin levels; power down outranks reset
      if (!pd_n_s) begin
         st_d.mode = swcp_pkg::SWCP_POWERED_DOWN;
      end else if (!rst_n_s) begin
         st_d.mode = swcp_pkg::SWCP_HELD_RESET;
      end else begin
         st_d.mode = swcp_pkg::SWCP_ACTIVE;
      end

      // wiper latch; select high and no pin edge leaves it alone
      case (st_d.mode)
         swcp_pkg::SWCP_HELD_RESET: begin
            st_d.latch = swcp_pkg::WIPER_MIDSCALE;
            st_d.out_cleared = 1'b1;
         end
         swcp_pkg::SWCP_POWERED_DOWN: begin
            // programming keeps working so a preset waits for release
            if (sel_rise && rst_n_s) begin
               st_d.latch = shift_word;
            end
         end
         swcp_pkg::SWCP_ACTIVE: begin
            if (rst_rise && sel_n_s) begin
               st_d.latch = swcp_pkg::WIPER_MIDSCALE;
            end else if (sel_rise) begin
               // shifter is frozen while select is high, so the word is
               // stable by the time the synchronised edge arrives
               st_d.latch = shift_word;
            end
         end
         default: begin
            st_d.latch = st_q.latch;
         end
      endcase

      // a fresh frame ends the forced-clear of the output latch
      if (sel_rise && rst_n_s) begin
         st_d.out_cleared = 1'b0;
      end

      // analog switch controls and the effective tap
      case (st_d.mode)
         swcp_pkg::SWCP_POWERED_DOWN: begin
            st_d.sw_a_closed = 1'b0;
            st_d.on_b = 1'b1;
            st_d.tap = swcp_pkg::WIPER_ZERO;
         end
         default: begin
            st_d.sw_a_closed = 1'b1;
            st_d.tap = st_d.latch;
            st_d.on_b = (st_d.latch == swcp_pkg::WIPER_ZERO);
         end
      endcase
      // one-hot tap decode, registered so the switch drives never glitch
      st_d.tap_sel = TAP_COUNT'(1) << st_d.tap;

      // open drain: enable low pulls the pad low, high lets it float
      st_d.out_oe_n = 1'b1;
      if (!sel_n_s && pd_n_s) begin
         // a one bit or a cleared latch both leave the pull-up in charge
         if (!out_bit_s && !st_d.out_cleared) begin
            st_d.out_oe_n = 1'b0;
         end
      end
      if (!pd_n_s || !rst_n_s) begin
         st_d.out_oe_n = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q.latch <= swcp_pkg::WIPER_RESET;
         st_q.tap <= swcp_pkg::WIPER_RESET;
         st_q.sel_n_prev <= 1'b1;
         st_q.rst_n_prev <= 1'b1;
         st_q.out_cleared <= 1'b1;
         st_q.out_oe_n <= 1'b1;
         st_q.sw_a_closed <= 1'b1;
         st_q.on_b <= 1'b0;
         st_q.tap_sel <= TAP_COUNT'(1) << swcp_pkg::WIPER_RESET;
         st_q.mode <= swcp_pkg::SWCP_ACTIVE;
      end else if (mclk_en) begin
         st_q <= st_d;
      end
   end

   // outputs

   assign serial_out = swcp_pkg::OD_DRIVE_LEVEL;
   assign serial_out_oe_n = st_q.out_oe_n;
   assign wiper_latch = st_q.latch;
   assign wiper_tap = st_q.tap;
   assign tap_select = st_q.tap_sel;
   assign terminal_a_switch = st_q.sw_a_closed;
   assign wiper_on_b = st_q.on_b;
   assign powered_down = (st_q.mode == swcp_pkg::SWCP_POWERED_DOWN);

endmodule : swcp_port

//--- swcp_port_bench.sv
// swcp_port_bench: self-checking bench of swcp_port with a host model.
// assumes a pull-up on the serial output.
module swcp_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic mclk_en = 1'b1;
   logic sys_rst = 1'b1;
   logic rst_n = 1'b1;
   logic pd_n = 1'b1;
   logic sclk, select_n, serial_in, so_o, so_oe_n, term_a, on_b, pd;
   logic [6:0] latch, tap;
   logic [127:0] tsel;
   logic [15:0] seen;
   wire logic sdo_line = so_oe_n ? 1'b1 : so_o;
   int fails = 0;
   int total_checks = 0;
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   swcp_host swcp_host_inst (.sclk(sclk), .select_n(select_n), .serial_in(serial_in),
      .sdo_line(sdo_line));
   swcp_port swcp_port_inst (.mclk(mclk), .mclk_en(mclk_en), .sys_rst(sys_rst),
      .sclk(sclk), .select_n(select_n), .serial_in(serial_in), .midscale_reset_n(rst_n),
      .power_down_n(pd_n), .serial_out(so_o), .serial_out_oe_n(so_oe_n),
      .wiper_latch(latch), .wiper_tap(tap), .tap_select(tsel), .terminal_a_switch(term_a),
      .wiper_on_b(on_b), .powered_down(pd));
   task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : check
   task automatic settle();
      repeat (10) @(posedge mclk);
      #1;
   endtask : settle
   task automatic t_load();
      swcp_host_inst.frame(16'h0055, 7, seen);
      settle();
      check(latch, 7'h55, "load");
      check(tsel, 128'h1 << 85, "tap");
      swcp_host_inst.frame(16'h002a, 7, seen);
      settle();
      check(seen, 16'h0055, "chain out");
      check(latch, 7'h2a, "msb first");
      swcp_host_inst.frame(16'h03b3, 10, seen);
      settle();
      check(seen, 16'h0157, "long out");
      check(latch, 7'h33, "extra bits");
      $display("load test done");
   endtask : t_load
   task automatic t_reset();
      @(posedge mclk) rst_n <= 1'b0;
      settle();
      check(latch, 7'h40, "midscale");
      check(so_oe_n, 1'b1, "out cleared");
      swcp_host_inst.frame(16'h007f, 7, seen);
      settle();
      check(latch, 7'h40, "held in reset");
      @(posedge mclk) rst_n <= 1'b1;
      settle();
      check(latch, 7'h40, "reset rise");
      swcp_host_inst.frame(16'h0019, 7, seen);
      settle();
      check(seen, 16'h007f, "out released after reset");
      check(latch, 7'h19, "load after reset");
      $display("reset test done");
   endtask : t_reset
   task automatic t_pd();
      @(posedge mclk) pd_n <= 1'b0;
      settle();
      check({term_a, on_b, tap}, {2'b01, 7'h00}, "shutdown");
      check(pd, 1'b1, "powered down flag");
      swcp_host_inst.frame(16'h0011, 7, seen);
      settle();
      check(seen, 16'h007f, "out off");
      check(latch, 7'h11, "load in shutdown");
      @(posedge mclk) pd_n <= 1'b1;
      settle();
      check({term_a, tap}, {1'b1, 7'h11}, "resume");
      check(pd, 1'b0, "powered down cleared");
      $display("shutdown test done");
   endtask : t_pd
   task automatic t_zero();
      swcp_host_inst.frame(16'h0000, 7, seen);
      settle();
      check({term_a, on_b, tap}, {2'b11, 7'h00}, "code zero");
      check(tsel, 128'h1, "zero tap select");
      $display("zero test done");
   endtask : t_zero
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge mclk);
      t_load();
      t_reset();
      t_pd();
      t_zero();
      close_out();
   end
endmodule : swcp_port_bench

//--- swcp_port_props.sv
// swcp_port_props: port-level checks of swcp_port.
// assumes mclk_en held high by the bench.
module swcp_port_props #(
   parameter int WIPER_W = 7,
   parameter int TAP_COUNT = 128
) (
   input wire logic mclk,
   input wire logic mclk_en,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic select_n,
   input wire logic serial_in,
   input wire logic midscale_reset_n,
   input wire logic power_down_n,
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   input wire logic [WIPER_W-1:0] wiper_latch,
   input wire logic [WIPER_W-1:0] wiper_tap,
   input wire logic [TAP_COUNT-1:0] tap_select,
   input wire logic terminal_a_switch,
   input wire logic wiper_on_b,
   input wire logic powered_down
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   tap_onehot_a: assert property (tap_select == (TAP_COUNT'(1) << wiper_tap))
      else $error("tap select not one-hot of tap");
   wiper_b_a: assert property (wiper_on_b == (wiper_tap == swcp_pkg::WIPER_ZERO))
      else $error("wiper on b disagrees with tap");
   term_a_a: assert property (terminal_a_switch == !powered_down)
      else $error("terminal a switch wrong");
   pd_tap_a: assert property (powered_down |-> wiper_tap == 7'h00 && serial_out_oe_n)
      else $error("power down tap or output wrong");
   tap_latch_a: assert property (!powered_down |-> wiper_tap == wiper_latch)
      else $error("tap differs from latch");
   od_low_a: assert property (serial_out == swcp_pkg::OD_DRIVE_LEVEL)
      else $error("serial out drives high");
   oe_idle_a: assert property (select_n [*6] |-> serial_out_oe_n)
      else $error("output driven while deselected");
   latch_hold_a: assert property ((select_n && midscale_reset_n && power_down_n) [*8]
      |=> $stable(wiper_latch))
      else $error("latch moved while idle");
   midscale_a: assert property ((!midscale_reset_n && power_down_n) [*6]
      |-> wiper_latch == swcp_pkg::WIPER_MIDSCALE && serial_out_oe_n)
      else $error("reset did not force midscale");
endmodule : swcp_port_props

bind swcp_port swcp_port_props #(.WIPER_W(WIPER_W), .TAP_COUNT(TAP_COUNT)) swcp_port_props_inst (
   .mclk(mclk), .mclk_en(mclk_en), .sys_rst(sys_rst), .sclk(sclk), .select_n(select_n),
   .serial_in(serial_in), .midscale_reset_n(midscale_reset_n), .power_down_n(power_down_n),
   .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .wiper_latch(wiper_latch),
   .wiper_tap(wiper_tap), .tap_select(tap_select), .terminal_a_switch(terminal_a_switch),
   .wiper_on_b(wiper_on_b), .powered_down(powered_down));

//--- swcp_shifter.sv
// swcp_shifter: input shifter and serial output latch, clocked by the serial clock.
// assumes the host keeps select and reset steady around each rising edge.
module swcp_shifter #(
   parameter int WIDTH = 7
) (
   input wire logic sclk,
   input wire logic clk_en,
   input wire logic shift_en,
   input wire logic clear_out,
   input wire logic serial_in,
   output logic [WIDTH-1:0] word,
   output logic out_bit
);

   typedef struct packed {
      logic [WIDTH-1:0] shifter;
      logic out_bit;
   } swcp_shift_state_t;

   swcp_shift_state_t st_q;
   swcp_shift_state_t st_d;

   always_comb begin
      st_d = st_q;
      if (shift_en) begin
         // msb first: older bits walk up, extras fall off the top
         st_d.shifter = {st_q.shifter[WIDTH-2:0], serial_in};
         st_d.out_bit = st_q.shifter[WIDTH-1];
      end
      if (clear_out) begin
         st_d.out_bit = 1'b0;
      end
   end

   // data path only; shifter content is undefined until first loaded
   always_ff @(posedge sclk) begin
      if (clk_en) begin
         st_q <= st_d;
      end
   end

   assign word = st_q.shifter;
   assign out_bit = st_q.out_bit;

endmodule : swcp_shifter

//--- swcp_sync.sv
// swcp_sync: three-stage synchroniser into the mclk domain, one lane per bit.
// assumes inputs are levels; a change is passed once stages two and three agree.
module swcp_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] IDLE = '1
) (
   input wire logic mclk,
   input wire logic mclk_en,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] agreed
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
   } swcp_sync_state_t;

   swcp_sync_state_t st_q;
   swcp_sync_state_t st_d;

   always_comb begin
      st_d.s1 = raw;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // filter: a lane moves only once stages two and three agree
      st_d.level = (st_q.s2 & st_q.s3) | (st_q.level & (st_q.s2 | st_q.s3));
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= {IDLE, IDLE, IDLE, IDLE};
      end else if (mclk_en) begin
         st_q <= st_d;
      end
   end

   assign agreed = st_q.level;

endmodule : swcp_sync
